// file: core/io_register_space_decode.sv
// module: core and flag registers of the port register space
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Port registers appear in data space at port address plus thirty-two.
// - Extended region is reached by loads and stores, never by short operations.
// - Bit set and clear work only in the lowest thirty-two addresses.
// - Bit test in the low range reports a skip on set or clear.
// - Writing one clears a status flag; writing zero leaves it.
// - Bit set and clear rewrite the whole register, clearing set flags other than the bit a clear targets.
module io_register_space_decode
(
    // clock and reset
    input  wire logic                    clk_sys_i,
    input  wire logic                    arst_n_i,
    // core access
    input  wire logic                    req_valid_i,
    input  wire io_space_pkg::io_req_s   req_i,
    output io_space_pkg::io_rsp_s        rsp_o,
    // extended region forwarding
    output logic [8:0]                   ext_addr_o,
    output logic [7:0]                   ext_wdata_o,
    output logic                         ext_we_o,
    output logic                         ext_re_o,
    input  wire logic [7:0]              ext_rdata_i,
    // hardware flag events, one vector per flag register
    input  wire logic [7:0]              t0_event_i,
    input  wire logic [7:0]              t1_event_i,
    input  wire logic [7:0]              t3_event_i,
    input  wire logic [7:0]              t4_event_i,
    input  wire logic [7:0]              pc_event_i,
    // core state seen by the core
    output logic [7:0]                   cond_flags_o,
    output logic [15:0]                  stack_ptr_o,
    output logic [1:0]                   far_page_o
);
    import io_space_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    io_decode_s dec;
    logic       legal;

    io_addr_decode u_decode
    (
        .req_i   (req_i),
        .dec_o   (dec),
        .legal_o (legal)
    );

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] flags_q [NUM_FLAG_REGS];
    logic [7:0] scratch_q [3];
    logic [7:0] far_page_q;
    logic [7:0] sp_low_q;
    logic [7:0] sp_high_q;
    logic [7:0] cond_q;
    logic [7:0] event_vec [NUM_FLAG_REGS];

    assign event_vec[0] = t0_event_i;
    assign event_vec[1] = t1_event_i;
    assign event_vec[2] = t3_event_i;
    assign event_vec[3] = t4_event_i;
    assign event_vec[4] = pc_event_i;

    // index of a flag register, or NUM_FLAG_REGS if none
    function automatic int flag_index(input logic [5:0] a);
        case (a)
            ADDR_T0_FLAGS: flag_index = 0;
            ADDR_T1_FLAGS: flag_index = 1;
            ADDR_T3_FLAGS: flag_index = 2;
            ADDR_T4_FLAGS: flag_index = 3;
            ADDR_PC_FLAGS: flag_index = 4;
            default:       flag_index = NUM_FLAG_REGS;
        endcase
    endfunction

    // implemented bits of a flag register
    function automatic logic [7:0] flag_mask(input int i);
        case (i)
            0:       flag_mask = MASK_T0_FLAGS;
            1:       flag_mask = MASK_T1_FLAGS;
            2:       flag_mask = MASK_T3_FLAGS;
            3:       flag_mask = MASK_T4_FLAGS;
            4:       flag_mask = MASK_PC_FLAGS;
            default: flag_mask = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // read path (pure, no side effects)
    // ------------------------------------------------------------
    logic [7:0] read_byte;
    int         rd_fi;

    always_comb
    begin
        rd_fi     = flag_index(dec.port_addr);
        read_byte = 8'h00;
        if (rd_fi < NUM_FLAG_REGS)
            read_byte = flags_q[rd_fi] & flag_mask(rd_fi);
        else
            case (dec.port_addr)
                ADDR_SCRATCH_0:  read_byte = scratch_q[0];
                ADDR_SCRATCH_1:  read_byte = scratch_q[1];
                ADDR_SCRATCH_2:  read_byte = scratch_q[2];
                ADDR_FAR_PAGE:   read_byte = far_page_q & MASK_FAR_PAGE;
                ADDR_SP_LOW:     read_byte = sp_low_q;
                ADDR_SP_HIGH:    read_byte = sp_high_q;
                ADDR_COND_FLAGS: read_byte = cond_q;
                default:         read_byte = 8'h00;
            endcase
    end

    // ------------------------------------------------------------
    // write value
    // ------------------------------------------------------------
    logic       do_write;
    logic [7:0] write_byte;
    logic [7:0] bit_onehot;

    always_comb
    begin
        bit_onehot = 8'h01 << req_i.bit_sel;
        do_write   = 1'b0;
        write_byte = req_i.wdata;
        if (req_valid_i && legal && dec.hit)
            case (req_i.kind)
                ACC_PORT_OUT, ACC_DATA_STORE:
                    do_write = 1'b1;
                ACC_BIT_SET:
                begin
                    do_write   = 1'b1;
                    write_byte = read_byte | bit_onehot;
                end
                ACC_BIT_CLEAR:
                begin
                    do_write   = 1'b1;
                    write_byte = read_byte & ~bit_onehot;
                end
                default:
                    do_write = 1'b0;
            endcase
    end

    // ------------------------------------------------------------
    // flag registers: event set wins over write-one clear
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_FLAG_REGS; g++)
        begin : g_flag
            logic [7:0] clr;
            assign clr = (do_write && flag_index(dec.port_addr) == g) ? write_byte : 8'h00;
            always_ff @(posedge clk_sys_i or negedge rst_n)
            begin
                if (!rst_n)
                    flags_q[g] <= RESET_BYTE;
                else
                    flags_q[g] <= ((flags_q[g] & ~clr) | event_vec[g])
                                  & flag_mask(g);
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // plain registers; reserved addresses ignore writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scratch_q[0] <= RESET_BYTE;
            scratch_q[1] <= RESET_BYTE;
            scratch_q[2] <= RESET_BYTE;
            far_page_q   <= RESET_BYTE;
            sp_low_q     <= RESET_SP_LOW;
            sp_high_q    <= RESET_SP_HIGH;
            cond_q       <= RESET_BYTE;
        end
        else if (do_write)
            case (dec.port_addr)
                ADDR_SCRATCH_0:  scratch_q[0] <= write_byte;
                ADDR_SCRATCH_1:  scratch_q[1] <= write_byte;
                ADDR_SCRATCH_2:  scratch_q[2] <= write_byte;
                ADDR_FAR_PAGE:   far_page_q   <= write_byte & MASK_FAR_PAGE;
                ADDR_SP_LOW:     sp_low_q     <= write_byte;
                ADDR_SP_HIGH:    sp_high_q    <= write_byte;
                ADDR_COND_FLAGS: cond_q       <= write_byte;
                default:         cond_q       <= cond_q;
            endcase
    end

    // ------------------------------------------------------------
    // answer, registered one cycle after the request
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsp_o    <= '0;
        end
        else
        begin
            rsp_o.ack     <= req_valid_i;
            rsp_o.err     <= req_valid_i & ~legal;
            rsp_o.ext_sel <= req_valid_i & legal & dec.ext;
            rsp_o.skip    <= req_valid_i && legal && req_i.kind == ACC_BIT_TEST
                             && (read_byte[req_i.bit_sel] == req_i.skip_on_set);
            rsp_o.rdata   <= (req_valid_i && legal && dec.hit) ? read_byte : 8'h00;
        end
    end

    // extended region strobes, combinational from the request
    assign ext_addr_o   = req_i.addr;
    assign ext_wdata_o  = req_i.wdata;
    assign ext_we_o     = req_valid_i & legal & dec.ext & (req_i.kind == ACC_DATA_STORE);
    assign ext_re_o     = req_valid_i & legal & dec.ext & (req_i.kind == ACC_DATA_LOAD);
    assign cond_flags_o = cond_q;
    assign stack_ptr_o  = {sp_high_q, sp_low_q};
    assign far_page_o   = far_page_q[1:0];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_data_alias;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (req_valid_i && req_i.kind == ACC_DATA_STORE && req_i.addr == 9'h03e)
        |=> (scratch_q[0] == $past(req_i.wdata));
    endproperty
    a_data_alias: assert property (p_data_alias) else $error("data alias write lost");

    property p_short_no_ext;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (req_i.kind == ACC_PORT_IN || req_i.kind == ACC_PORT_OUT) |-> !ext_we_o && !ext_re_o;
    endproperty
    a_short_no_ext: assert property (p_short_no_ext) else $error("short op hit ext");

    property p_ext_load;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (req_valid_i && req_i.kind == ACC_DATA_LOAD && req_i.addr >= DATA_EXT_FIRST)
        |=> rsp_o.ext_sel && !rsp_o.err;
    endproperty
    a_ext_load: assert property (p_ext_load) else $error("ext load not forwarded");

    property p_bit_high_refused;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (req_valid_i && req_i.kind == ACC_BIT_SET && req_i.addr > 9'h01f) |=> rsp_o.err;
    endproperty
    a_bit_high_refused: assert property (p_bit_high_refused) else $error("bit op not refused");

    property p_skip;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (req_valid_i && req_i.kind == ACC_BIT_TEST && req_i.addr == 9'h01e)
        |=> rsp_o.skip == ($past(scratch_q[0][req_i.bit_sel]) == $past(req_i.skip_on_set));
    endproperty
    a_skip: assert property (p_skip) else $error("skip result wrong");

    property p_w1c;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (do_write && dec.port_addr == ADDR_PC_FLAGS && write_byte[0] && !pc_event_i[0])
        |=> !flags_q[4][0];
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared");

    property p_w0_keep;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (flags_q[4][0] && !(do_write && dec.port_addr == ADDR_PC_FLAGS && write_byte[0]))
        |=> flags_q[4][0];
    endproperty
    a_w0_keep: assert property (p_w0_keep) else $error("flag lost");

    property p_rmw_clear;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (req_valid_i && (req_i.kind == ACC_BIT_SET || req_i.kind == ACC_BIT_CLEAR)
         && req_i.addr == 9'h015
         && flags_q[0][0] && req_i.bit_sel != 3'h0 && !t0_event_i[0])
        |=> !flags_q[0][0];
    endproperty
    a_rmw_clear: assert property (p_rmw_clear) else $error("rmw kept flag");

    property p_reserved_zero;
        @(posedge clk_sys_i) disable iff (!rst_n)
        (req_valid_i && req_i.kind == ACC_PORT_IN && req_i.addr == 9'h03c) |=> rsp_o.rdata == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved read nonzero");

endmodule

`default_nettype wire

// file: core/io_space_pkg.sv
// package: io register space map, access kinds and field layouts
package io_space_pkg;

    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam logic [5:0] IO_SPACE_SIZE_M1   = 6'h3f;     // 64 port-style locations
    localparam logic [8:0] DATA_IO_OFFSET     = 9'h020;    // data address = port address + this
    localparam logic [8:0] DATA_EXT_FIRST     = 9'h060;    // extended region start
    localparam logic [8:0] DATA_EXT_LAST      = 9'h1ff;    // extended region end
    localparam logic [5:0] BIT_OP_LIMIT       = 6'h1f;     // last bit-accessible address

    localparam logic [5:0] ADDR_T0_FLAGS      = 6'h15;
    localparam logic [5:0] ADDR_T1_FLAGS      = 6'h16;
    localparam logic [5:0] ADDR_T3_FLAGS      = 6'h18;
    localparam logic [5:0] ADDR_T4_FLAGS      = 6'h19;
    localparam logic [5:0] ADDR_PC_FLAGS      = 6'h1b;
    localparam logic [5:0] ADDR_SCRATCH_0     = 6'h1e;
    localparam logic [5:0] ADDR_SCRATCH_1     = 6'h2a;
    localparam logic [5:0] ADDR_SCRATCH_2     = 6'h2b;
    localparam logic [5:0] ADDR_FAR_PAGE      = 6'h3b;
    localparam logic [5:0] ADDR_SP_LOW        = 6'h3d;
    localparam logic [5:0] ADDR_SP_HIGH       = 6'h3e;
    localparam logic [5:0] ADDR_COND_FLAGS    = 6'h3f;

    // ------------------------------------------------------------
    // implemented bit masks (reserved bits read zero)
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_T0_FLAGS      = 8'h07;
    localparam logic [7:0] MASK_T1_FLAGS      = 8'h2f;
    localparam logic [7:0] MASK_T3_FLAGS      = 8'h2f;
    localparam logic [7:0] MASK_T4_FLAGS      = 8'he4;
    localparam logic [7:0] MASK_PC_FLAGS      = 8'h01;
    localparam logic [7:0] MASK_FAR_PAGE      = 8'h03;
    localparam logic [7:0] RESET_BYTE         = 8'h00;
    localparam logic [7:0] RESET_SP_LOW       = 8'hff;
    localparam logic [7:0] RESET_SP_HIGH      = 8'h0a;

    localparam int         NUM_FLAG_REGS      = 5;

    // ------------------------------------------------------------
    // access kinds issued by the core
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ACC_NONE       = 3'b000,
        ACC_PORT_IN    = 3'b001,  // short register-in
        ACC_PORT_OUT   = 3'b010,  // short register-out
        ACC_DATA_LOAD  = 3'b011,  // data_load_op / direct_load_op / displaced_load_op
        ACC_DATA_STORE = 3'b100,  // data_store_op / direct_store_op
        ACC_BIT_SET    = 3'b101,  // set_io_bit_op
        ACC_BIT_CLEAR  = 3'b110,  // clear_io_bit_op
        ACC_BIT_TEST   = 3'b111   // skip_if_io_bit_set_op / skip_if_io_bit_clear_op
    } access_kind_e;

    // request from the core
    typedef struct packed
    {
        access_kind_e kind;
        logic [8:0]   addr;      // port address (5:0) or data address (8:0)
        logic [2:0]   bit_sel;
        logic         skip_on_set; // bit test: 1 skip if set, 0 skip if clear
        logic [7:0]   wdata;
    } io_req_s;

    // answer to the core
    typedef struct packed
    {
        logic       ack;
        logic       err;         // access refused
        logic       ext_sel;     // access forwarded to the extended region
        logic       skip;
        logic [7:0] rdata;
    } io_rsp_s;

    // decoded target inside port space
    typedef struct packed
    {
        logic       hit;         // valid port-space address
        logic [5:0] port_addr;
        logic       ext;         // extended region
    } io_decode_s;

endpackage

// file: core/io_addr_decode.sv
// module: maps core accesses onto port-space addresses
`timescale 1ns/1ps
`default_nettype none

module io_addr_decode
(
    // request
    input  wire io_space_pkg::io_req_s    req_i,
    // decoded target
    output io_space_pkg::io_decode_s      dec_o,
    output logic                          legal_o
);
    import io_space_pkg::*;

    // ------------------------------------------------------------
    // address translation and legality
    // ------------------------------------------------------------
    logic [8:0] port_off;

    // data space subtracts the fixed offset, port space is used directly
    always_comb
    begin
        port_off      = req_i.addr - DATA_IO_OFFSET;
        dec_o.hit     = 1'b0;
        dec_o.ext     = 1'b0;
        dec_o.port_addr = 6'h00;
        legal_o       = 1'b0;
        case (req_i.kind)
            ACC_PORT_IN, ACC_PORT_OUT:
            begin
                // short operations reach only the 64 low locations
                dec_o.hit       = (req_i.addr[8:6] == 3'b000);
                dec_o.port_addr = req_i.addr[5:0];
                legal_o         = dec_o.hit;
            end
            ACC_DATA_LOAD, ACC_DATA_STORE:
            begin
                if ((req_i.addr >= DATA_IO_OFFSET) && (req_i.addr < DATA_EXT_FIRST))
                begin
                    dec_o.hit       = 1'b1;
                    dec_o.port_addr = port_off[5:0];
                end
                dec_o.ext = (req_i.addr >= DATA_EXT_FIRST)
                          && (req_i.addr <= DATA_EXT_LAST);
                legal_o   = dec_o.hit | dec_o.ext;
            end
            ACC_BIT_SET, ACC_BIT_CLEAR, ACC_BIT_TEST:
            begin
                // bit operations only up to and including the limit
                dec_o.hit       = (req_i.addr[8:5] == 4'h0);
                dec_o.port_addr = req_i.addr[5:0];
                legal_o         = dec_o.hit;
            end
            default:
            begin
                legal_o = 1'b0;
            end
        endcase
    end

endmodule

`default_nettype wire

// file: tb/core_access_model.sv
// core-side access model issuing requests to the port register space
`timescale 1ns/1ps
`default_nettype none

module core_access_model
(
    // clock
    input  wire logic                    clk_sys_i,
    // request towards the register space
    output logic                         req_valid_o,
    output io_space_pkg::io_req_s        req_o,
    // answer and extended strobes
    input  wire io_space_pkg::io_rsp_s   rsp_i,
    input  wire logic                    ext_we_i,
    input  wire logic                    ext_re_i
);
    import io_space_pkg::*;

    // ------------------------------------------------------------
    // request driving
    // ------------------------------------------------------------
    // idle at time zero
    initial
    begin
        req_valid_o = 1'b0;
        req_o       = '0;
    end

    // one access entered just after a rising edge; valid stays up so calls chain
    // back to back; callers keep reserved bits zero but may read reserved addresses
    task automatic access(input access_kind_e k, input logic [8:0] a, input logic [2:0] b,
                          input logic sos, input logic [7:0] wd,
                          output io_rsp_s rsp, output logic we, output logic re);
        req_valid_o = 1'b1;
        req_o       = '{kind: k, addr: a, bit_sel: b, skip_on_set: sos, wdata: wd};
        @(negedge clk_sys_i);
        we = ext_we_i;                   // strobes settle within the request cycle
        re = ext_re_i;
        @(posedge clk_sys_i);
        #1;
        rsp = rsp_i;                     // answer stands just after the take edge
    endtask

    // drop the request; fields are inverted so stale values are never trusted
    task automatic idle();
        req_valid_o = 1'b0;
        req_o       = ~req_o;
        @(posedge clk_sys_i);
        #1;
    endtask
endmodule

`default_nettype wire

// file: tb/io_register_space_decode_tb_top.sv
// testbench: table and hand-written tests of the port register space
`timescale 1ns/1ps
`default_nettype none

module io_register_space_decode_tb_top;
    import io_space_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    typedef struct
    {
        access_kind_e k;
        logic [8:0]   a;
        logic [2:0]   b;
        logic         sos;
        logic [7:0]   wd;
        logic         err;
        logic         chk;
        logic [7:0]   rd;
        logic         skip;
    } row_s;

    logic        clk_sys_i;
    logic        arst_n_i;
    logic        req_valid;
    io_req_s     req;
    io_rsp_s     rsp_o;
    io_rsp_s     rsp;
    logic [8:0]  ext_addr;
    logic [7:0]  ext_wdata;
    logic        ext_we;
    logic        ext_re;
    logic        we;
    logic        re;
    logic [7:0]  ev;
    logic [7:0]  cond_flags;
    logic [15:0] stack_ptr;
    logic [1:0]  far_page;
    int          error_cnt;
    int          samples_checked;
    int          cyc;
    logic [5:0]  fl_addr [5] = '{6'h15, 6'h16, 6'h18, 6'h19, 6'h1b};
    logic [7:0]  fl_mask [5] = '{8'h07, 8'h2f, 8'h2f, 8'he4, 8'h01};

    // ordinary cases: kind, addr, bit, skip_on_set, wdata, err, check rdata, rdata, skip
    row_s rows [19] = '{
        '{ACC_DATA_STORE, 9'h03e, 3'h0, 1'b0, 8'h55, 1'b0, 1'b0, 8'h00, 1'b0},
        '{ACC_PORT_IN,    9'h01e, 3'h0, 1'b0, 8'h00, 1'b0, 1'b1, 8'h55, 1'b0},
        '{ACC_PORT_OUT,   9'h02a, 3'h0, 1'b0, 8'ha5, 1'b0, 1'b0, 8'h00, 1'b0},
        '{ACC_DATA_LOAD,  9'h04a, 3'h0, 1'b0, 8'h00, 1'b0, 1'b1, 8'ha5, 1'b0},
        '{ACC_PORT_OUT,   9'h03b, 3'h0, 1'b0, 8'h03, 1'b0, 1'b0, 8'h00, 1'b0},
        '{ACC_DATA_LOAD,  9'h05b, 3'h0, 1'b0, 8'h00, 1'b0, 1'b1, 8'h03, 1'b0},
        '{ACC_PORT_IN,    9'h03c, 3'h0, 1'b0, 8'h00, 1'b0, 1'b1, 8'h00, 1'b0},
        '{ACC_PORT_IN,    9'h040, 3'h0, 1'b0, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0},
        '{ACC_PORT_OUT,   9'h060, 3'h0, 1'b0, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0},
        '{ACC_BIT_SET,    9'h02a, 3'h7, 1'b0, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0},
        '{ACC_BIT_CLEAR,  9'h03f, 3'h0, 1'b0, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0},
        '{ACC_BIT_SET,    9'h01e, 3'h7, 1'b0, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0},
        '{ACC_BIT_CLEAR,  9'h01e, 3'h0, 1'b0, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0},
        '{ACC_PORT_IN,    9'h01e, 3'h0, 1'b0, 8'h00, 1'b0, 1'b1, 8'hd4, 1'b0},
        '{ACC_BIT_TEST,   9'h01e, 3'h2, 1'b1, 8'h00, 1'b0, 1'b0, 8'h00, 1'b1},
        '{ACC_BIT_TEST,   9'h01e, 3'h0, 1'b0, 8'h00, 1'b0, 1'b0, 8'h00, 1'b1},
        '{ACC_BIT_TEST,   9'h01e, 3'h0, 1'b1, 8'h00, 1'b0, 1'b0, 8'h00, 1'b0},
        '{ACC_BIT_TEST,   9'h02a, 3'h0, 1'b1, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0},
        '{ACC_DATA_LOAD,  9'h010, 3'h0, 1'b0, 8'h00, 1'b1, 1'b0, 8'h00, 1'b0}
    };

    // ------------------------------------------------------------
    // design, core model, clock
    // ------------------------------------------------------------
    io_register_space_decode DUT
    (
        .clk_sys_i    (clk_sys_i),
        .arst_n_i     (arst_n_i),
        .req_valid_i  (req_valid),
        .req_i        (req),
        .rsp_o        (rsp_o),
        .ext_addr_o   (ext_addr),
        .ext_wdata_o  (ext_wdata),
        .ext_we_o     (ext_we),
        .ext_re_o     (ext_re),
        .ext_rdata_i  (8'h00),
        .t0_event_i   (ev),
        .t1_event_i   (ev),
        .t3_event_i   (ev),
        .t4_event_i   (ev),
        .pc_event_i   (ev),
        .cond_flags_o (cond_flags),
        .stack_ptr_o  (stack_ptr),
        .far_page_o   (far_page)
    );

    core_access_model core
    (
        .clk_sys_i    (clk_sys_i),
        .req_valid_o  (req_valid),
        .req_o        (req),
        .rsp_i        (rsp_o),
        .ext_we_i     (ext_we),
        .ext_re_i     (ext_re)
    );

    // 40 MHz system clock
    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard, well above the some sixty cycles the tests need
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            final_report();
        end
    end

    // reset then wait three edges before the first request
    task automatic do_reset(input int n);
        arst_n_i = 1'b0;
        repeat (n) @(posedge clk_sys_i);
        #1;
        chk_val({cond_flags, 6'h00, far_page}, 16'h0000);
        chk_val(stack_ptr, 16'h0aff);
        chk_bit(rsp_o.ack, 1'b0);
        arst_n_i = 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic rd_port(input logic [5:0] a, input logic [7:0] exp);
        core.access(ACC_PORT_IN, {3'h0, a}, 3'h0, 1'b0, 8'h00, rsp, we, re);
        chk_val(rsp.rdata, exp);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        error_cnt       = 0;
        samples_checked = 0;
        cyc             = 0;
        ev              = 8'h00;
        do_reset(8);
        // table rows issued back to back
        foreach (rows[i])
        begin
            core.access(rows[i].k, rows[i].a, rows[i].b, rows[i].sos, rows[i].wd, rsp, we, re);
            chk_bit(rsp.ack, 1'b1);
            chk_bit(rsp.err, rows[i].err);
            if (rows[i].chk)
                chk_val(rsp.rdata, rows[i].rd);
            if (rows[i].k == ACC_BIT_TEST)
                chk_bit(rsp.skip, rows[i].skip);
        end
        // core state through data-space stores
        core.access(ACC_DATA_STORE, 9'h05d, 3'h0, 1'b0, 8'h34, rsp, we, re);
        core.access(ACC_DATA_STORE, 9'h05e, 3'h0, 1'b0, 8'h12, rsp, we, re);
        core.access(ACC_DATA_STORE, 9'h05f, 3'h0, 1'b0, 8'h81, rsp, we, re);
        core.idle();
        chk_val(stack_ptr, 16'h1234);
        chk_val({cond_flags, 6'h00, far_page}, 16'h8103);
        // extended region reached by loads and stores only
        core.access(ACC_DATA_STORE, 9'h1ff, 3'h0, 1'b0, 8'h5a, rsp, we, re);
        chk_val({12'h000, we, re, rsp.ext_sel, rsp.err}, 16'h000a);
        chk_val({7'h00, ext_addr}, 16'h01ff);
        chk_val({8'h00, ext_wdata}, 16'h005a);
        core.access(ACC_DATA_LOAD, 9'h060, 3'h0, 1'b0, 8'h00, rsp, we, re);
        chk_val({12'h000, we, re, rsp.ext_sel, rsp.err}, 16'h0006);
        core.access(ACC_PORT_IN, 9'h060, 3'h0, 1'b0, 8'h00, rsp, we, re);
        chk_val({12'h000, we, re, rsp.ext_sel, rsp.err}, 16'h0001);
        // raise every flag event for one cycle; reserved bits must stay zero
        core.idle();
        ev = 8'hff;
        @(posedge clk_sys_i);
        #1;
        ev = 8'h00;
        for (int i = 0; i < 5; i++)
            rd_port(fl_addr[i], fl_mask[i]);
        rd_port(6'h1b, 8'h01);
        // write one clears, write zero keeps
        core.access(ACC_PORT_OUT, 9'h01b, 3'h0, 1'b0, 8'h01, rsp, we, re);
        rd_port(6'h1b, 8'h00);
        core.access(ACC_PORT_OUT, 9'h015, 3'h0, 1'b0, 8'h02, rsp, we, re);
        rd_port(6'h15, 8'h05);
        // bit operations write set flags back as one; the cleared bit was one and stays set
        core.access(ACC_BIT_CLEAR, 9'h015, 3'h2, 1'b0, 8'h00, rsp, we, re);
        rd_port(6'h15, 8'h04);
        core.access(ACC_BIT_SET, 9'h016, 3'h0, 1'b0, 8'h00, rsp, we, re);
        rd_port(6'h16, 8'h00);
        // second reset in mid-run
        core.idle();
        do_reset(2);
        rd_port(6'h1e, 8'h00);
        rd_port(6'h15, 8'h00);
        core.idle();
        final_report();
    end
endmodule

`default_nettype wire
